// file: mesh_payload_pkg.sv
// shared constants and types for the mesh thread payload builder
// assumes a single 125 MHz core clock domain
package mesh_payload_pkg;

   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned ROW_BITS = 256;
   localparam int unsigned DWORD_BITS = 32;
   localparam int unsigned LANE_IDX_BITS = 16;
   localparam int unsigned MAX_LANES = 32;
   localparam int unsigned TAG_BITS = 10;
   localparam int unsigned TAG_COUNT = 1024;
   localparam int unsigned TALLY_BITS = 64;
   localparam int unsigned GROUP_SIZE_BITS = 11;
   localparam int unsigned SLICE_COUNT = 4;
   localparam int unsigned SLICE_SEL_BITS = 2;

   // per-primitive read length ceiling in 256-bit units
   localparam logic [4:0] PRIM_READ_LEN_MAX = 5'h1f;

   // header dword positions
   localparam int unsigned HDR_DW_TASK_OFS = 7;
   localparam int unsigned HDR_DW_MESH = 6;
   localparam int unsigned HDR_DW_SCRATCH = 5;
   localparam int unsigned TASK_SEL_LSB = 16;
   localparam int unsigned TASK_SEL_MSB = 24;
   localparam int unsigned EXTENT_X_LSB = 16;
   localparam int unsigned SCRATCH_LSB = 10;

   // register address map
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_SCRATCH = 8'h04;
   localparam logic [7:0] ADDR_INLINE_BASE = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h28;
   localparam logic [7:0] ADDR_TALLY_BASE = 8'h40;
   localparam logic [31:0] RESET_CTRL = 32'h0000_0000;
   localparam logic [TALLY_BITS-1:0] RESET_TALLY = 64'h0;

   // ctrl bit positions
   localparam int unsigned CTRL_INLINE_EMIT = 0;
   localparam int unsigned CTRL_TASK_EN = 1;
   localparam int unsigned CTRL_DIM_3D = 2;
   localparam int unsigned CTRL_LEN_LSB = 8;

   typedef enum logic [1:0] {
      SIMD8 = 2'h0,
      SIMD16 = 2'h1,
      SIMD32 = 2'h2
   } simd_width_t;

   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_HDR = 5'b00010,
      ST_LID_LO = 5'b00100,
      ST_LID_HI = 5'b01000,
      ST_INLINE = 5'b10000
   } build_state_t;

endpackage

// file: tally_bus_if.sv
// interface carrying tally increments and reads between builder and bank
// assumes one clock domain shared by both modports
`timescale 1ns/1ps
interface tally_bus_if;
   import mesh_payload_pkg::*;
   logic inc;
   logic [SLICE_SEL_BITS-1:0] inc_slice;
   logic [GROUP_SIZE_BITS-1:0] inc_amount;
   logic [SLICE_SEL_BITS-1:0] rd_slice;
   logic rd_hi;
   logic [31:0] rd_data;
   modport builder (output inc, inc_slice, inc_amount, rd_slice, rd_hi,
      input rd_data);
   modport bank (input inc, inc_slice, inc_amount, rd_slice, rd_hi,
      output rd_data);
endinterface

// file: slice_tally_bank.sv
// per-slice mesh invocation tally counters with registered read data
// assumes the builder pulses inc once per whole group dispatch
`timescale 1ns/1ps
module slice_tally_bank
   import mesh_payload_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   tally_bus_if.bank tb
);

   logic [TALLY_BITS-1:0] tally_reg [SLICE_COUNT];
   logic [31:0] rd_reg;
   logic [TALLY_BITS-1:0] sel_tally;

   assign sel_tally = tally_reg[tb.rd_slice];

   ////////////////////////////////////////////////////////////////////////
   genvar g;
   generate
      for (g = 0; g < SLICE_COUNT; g++) begin : g_slice
         always_ff @(posedge core_clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
               tally_reg[g] <= RESET_TALLY;
            end else if (tb.inc && tb.inc_slice == g) begin
               // wraps on overflow
               tally_reg[g] <= tally_reg[g] +
                  TALLY_BITS'(tb.inc_amount);
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rd_reg <= 32'h0;
      end else begin
         rd_reg <= tb.rd_hi ? sel_tally[63:32] : sel_tally[31:0];
      end
   end

   assign tb.rd_data = rd_reg;

endmodule // slice_tally_bank

// file: mesh_thread_payload_builder.sv
// mesh thread payload builder: header, lane indices, inline parameter row
// assumes dispatch requests are synchronous to core_clk_i
// Overview of operation
// - per-primitive read length capped at 31 rows
// - one tally counter per graphics slice unit
// - tally grows by group size per dispatch
// - execution unit thread dispatches never bump tally
// - payload: header, indices, optional inline
// - 16-bit indices in row 1, or 1-2
// - index is lane position in whole group
// - inline row follows indices when emit set
// - dword 7 holds task entry offset
// - dword 6 high holds x extent in 3d
// - dword 6 low holds mesh entry offset
// - dword 5 high holds scratch surface index
// - dword 5 low holds unique thread tag
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module mesh_thread_payload_builder
   import mesh_payload_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   // register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // group dispatch start
   input wire logic group_start_i,
   input wire logic [GROUP_SIZE_BITS-1:0] group_size_i,
   input wire logic [SLICE_SEL_BITS-1:0] group_slice_i,
   // per-thread dispatch request
   input wire logic thread_valid_i,
   output logic thread_ready_o,
   input wire logic [1:0] thread_simd_i,
   input wire logic [GROUP_SIZE_BITS-1:0] thread_lane_base_i,
   input wire logic [15:0] thread_extent_x_i,
   input wire logic [15:0] thread_mesh_ofs_i,
   input wire logic [8:0] thread_task_sel_i,
   input wire logic [15:0] thread_task_ofs_i,
   // thread tag release
   input wire logic tag_free_i,
   input wire logic [TAG_BITS-1:0] tag_free_id_i,
   // payload row stream to execution unit core
   output logic row_valid_o,
   input wire logic row_ready_i,
   output logic [ROW_BITS-1:0] row_data_o,
   output logic [2:0] row_index_o,
   output logic row_last_o,
   output logic [4:0] prim_read_len_o
);

   build_state_t state_reg, state_next;
   logic [31:0] ctrl_reg;
   logic [21:0] scratch_reg;
   logic [DWORD_BITS-1:0] inline_reg [8];
   logic [TAG_COUNT-1:0] tag_busy_reg;
   logic [TAG_BITS-1:0] tag_reg;
   simd_width_t simd_reg;
   logic [GROUP_SIZE_BITS-1:0] base_reg;
   logic [15:0] ext_reg, mofs_reg, tofs_reg;
   logic [8:0] tsel_reg;
   logic [ROW_BITS-1:0] row_reg;
   logic [2:0] idx_reg;
   logic valid_reg, last_reg;
   logic rd_pend_reg;
   logic [31:0] rdata_reg;
   tally_bus_if tb();

   ////////////////////////////////////////////////////////////////////////
   // register decode
   logic wr_ctrl, wr_scratch, wr_inline, rd_tally;
   logic [2:0] inline_sel;
   logic [4:0] len_raw;
   assign wr_ctrl = reg_wr_i && reg_addr_i == ADDR_CTRL;
   assign wr_scratch = reg_wr_i && reg_addr_i == ADDR_SCRATCH;
   assign wr_inline = reg_wr_i && reg_addr_i >= ADDR_INLINE_BASE &&
      reg_addr_i < ADDR_STATUS;
   assign inline_sel = reg_addr_i[4:2] - 3'h2;
   assign rd_tally = reg_addr_i >= ADDR_TALLY_BASE &&
      reg_addr_i < ADDR_TALLY_BASE + 8'h20;
   assign len_raw = ctrl_reg[CTRL_LEN_LSB +: 5];
   // the 5-bit field cannot pass 31
   assign prim_read_len_o = len_raw > PRIM_READ_LEN_MAX ?
      PRIM_READ_LEN_MAX : len_raw;

   logic emit, task_en, dim3d;
   assign emit = ctrl_reg[CTRL_INLINE_EMIT];
   assign task_en = ctrl_reg[CTRL_TASK_EN];
   assign dim3d = ctrl_reg[CTRL_DIM_3D];

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ctrl_reg <= RESET_CTRL;
         scratch_reg <= 22'h0;
      end else begin
         if (wr_ctrl) ctrl_reg <= reg_wdata_i & 32'h0000_1f07;
         if (wr_scratch) scratch_reg <= reg_wdata_i[21:0];
      end
   end

   // software fills the inline words
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (int i = 0; i < 8; i++) inline_reg[i] <= 32'h0;
      end else if (wr_inline) begin
         inline_reg[inline_sel] <= reg_wdata_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // tally bank: only group starts count
   assign tb.inc = group_start_i;
   assign tb.inc_slice = group_slice_i;
   assign tb.inc_amount = group_size_i;
   assign tb.rd_slice = reg_addr_i[3 +: SLICE_SEL_BITS];
   assign tb.rd_hi = reg_addr_i[2];

   slice_tally_bank u_bank (
      .core_clk_i(core_clk_i),
      .arst_n_i(arst_n_i),
      .tb(tb.bank)
   );

   logic [31:0] rd_mux;
   logic rd_is_tally;
   assign rd_mux = reg_addr_i == ADDR_CTRL ? ctrl_reg :
      reg_addr_i == ADDR_SCRATCH ? {10'h0, scratch_reg} :
      wr_inline || (reg_addr_i >= ADDR_INLINE_BASE &&
         reg_addr_i < ADDR_STATUS) ? inline_reg[inline_sel] :
      reg_addr_i == ADDR_STATUS ? {27'h0, state_reg} : 32'h0;
   assign rd_is_tally = reg_rd_i && rd_tally;

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_reg <= 32'h0;
         rd_pend_reg <= 1'b0;
      end else begin
         rdata_reg <= reg_rd_i ? rd_mux : 32'h0;
         rd_pend_reg <= rd_is_tally;
      end
   end

   assign reg_rdata_o = rd_pend_reg ? tb.rd_data : rdata_reg;

   ////////////////////////////////////////////////////////////////////////
   // thread tag allocation: lowest free tag
   logic [TAG_BITS-1:0] free_tag;
   logic tag_avail;
   always_comb begin
      free_tag = '0;
      tag_avail = 1'b0;
      for (int i = TAG_COUNT - 1; i >= 0; i--) begin
         if (!tag_busy_reg[i]) begin
            free_tag = TAG_BITS'(i);
            tag_avail = 1'b1;
         end
      end
   end

   logic accept;
   assign thread_ready_o = state_reg == ST_IDLE && tag_avail;
   assign accept = thread_valid_i && thread_ready_o;

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tag_busy_reg <= '0;
      end else begin
         for (int i = 0; i < TAG_COUNT; i++) begin
            // allocation wins over a same-cycle release
            if (accept && free_tag == TAG_BITS'(i))
               tag_busy_reg[i] <= 1'b1;
            else if (tag_free_i && tag_free_id_i == TAG_BITS'(i))
               tag_busy_reg[i] <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // row builders
   logic [ROW_BITS-1:0] hdr_row, lid_lo_row, lid_hi_row, inline_row;
   always_comb begin
      hdr_row = '0;
      hdr_row[HDR_DW_TASK_OFS*32 +: 32] = task_en ?
         {7'h0, tsel_reg, tofs_reg} : 32'h0;
      hdr_row[HDR_DW_MESH*32 + EXTENT_X_LSB +: 16] =
         dim3d ? ext_reg : 16'h0;
      hdr_row[HDR_DW_MESH*32 +: 16] = mofs_reg;
      hdr_row[HDR_DW_SCRATCH*32 + SCRATCH_LSB +: 22] =
         scratch_reg;
      hdr_row[HDR_DW_SCRATCH*32 +: TAG_BITS] = tag_reg;
   end

   // group-relative lane position
   always_comb begin
      lid_lo_row = '0;
      lid_hi_row = '0;
      for (int l = 0; l < 16; l++) begin
         lid_lo_row[l*LANE_IDX_BITS +: LANE_IDX_BITS] =
            16'(base_reg) + 16'(l);
         lid_hi_row[l*LANE_IDX_BITS +: LANE_IDX_BITS] =
            16'(base_reg) + 16'(l + 16);
      end
      if (simd_reg == SIMD8) lid_lo_row[255:128] = '0;
   end

   always_comb begin
      for (int i = 0; i < 8; i++) inline_row[i*32 +: 32] = inline_reg[i];
   end

   ////////////////////////////////////////////////////////////////////////
   // payload sequencer
   logic row_take;
   assign row_take = valid_reg && row_ready_i;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: if (accept) state_next = ST_HDR;
         ST_HDR: if (row_take) state_next = ST_LID_LO;
         ST_LID_LO: if (row_take) begin
            state_next = simd_reg == SIMD32 ? ST_LID_HI :
               emit ? ST_INLINE : ST_IDLE;
         end
         ST_LID_HI: if (row_take) state_next = emit ? ST_INLINE : ST_IDLE;
         ST_INLINE: if (row_take) state_next = ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
   end

   logic [ROW_BITS-1:0] row_next;
   logic [2:0] idx_next;
   logic last_next;
   assign row_next = state_next == ST_HDR ? hdr_row :
      state_next == ST_LID_LO ? lid_lo_row :
      state_next == ST_LID_HI ? lid_hi_row : inline_row;
   assign idx_next = state_next == ST_HDR ? 3'h0 :
      state_next == ST_LID_LO ? 3'h1 :
      state_next == ST_LID_HI ? 3'h2 :
      simd_reg == SIMD32 ? 3'h3 : 3'h2;
   assign last_next = state_next == ST_INLINE ||
      (state_next == ST_LID_LO && simd_reg != SIMD32 && !emit) ||
      (state_next == ST_LID_HI && !emit);

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_reg <= ST_IDLE;
         simd_reg <= SIMD8;
         tag_reg <= '0;
         base_reg <= '0;
         ext_reg <= 16'h0;
         mofs_reg <= 16'h0;
         tofs_reg <= 16'h0;
         tsel_reg <= 9'h0;
      end else begin
         state_reg <= state_next;
         if (accept) begin
            simd_reg <= simd_width_t'(thread_simd_i);
            tag_reg <= free_tag;
            base_reg <= thread_lane_base_i;
            ext_reg <= thread_extent_x_i;
            mofs_reg <= thread_mesh_ofs_i;
            tofs_reg <= thread_task_ofs_i;
            tsel_reg <= thread_task_sel_i;
         end
      end
   end

   // header row is built one cycle after accept, so load rows late
   logic load_row;
   assign load_row = state_reg != state_next && state_next != ST_IDLE &&
      state_next != ST_HDR;

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         row_reg <= '0;
         idx_reg <= 3'h0;
         valid_reg <= 1'b0;
         last_reg <= 1'b0;
      end else if (state_reg == ST_HDR && !valid_reg) begin
         row_reg <= hdr_row;
         idx_reg <= 3'h0;
         valid_reg <= 1'b1;
         last_reg <= 1'b0;
      end else if (load_row) begin
         row_reg <= row_next;
         idx_reg <= idx_next;
         valid_reg <= 1'b1;
         last_reg <= last_next;
      end else if (row_take) begin
         valid_reg <= 1'b0;
      end
   end

   assign row_valid_o = valid_reg;
   assign row_data_o = row_reg;
   assign row_index_o = idx_reg;
   assign row_last_o = last_reg;

endmodule // mesh_thread_payload_builder

// file: mesh_payload_monitor.sv
// checker on the mesh thread payload builder ports
// assumes it is bound to every builder instance, one clock domain
`timescale 1ns/1ps
module mesh_payload_monitor
   import mesh_payload_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic thread_valid_i,
   input wire logic thread_ready_o,
   input wire logic [1:0] thread_simd_i,
   input wire logic [GROUP_SIZE_BITS-1:0] thread_lane_base_i,
   input wire logic [15:0] thread_extent_x_i,
   input wire logic [15:0] thread_mesh_ofs_i,
   input wire logic [8:0] thread_task_sel_i,
   input wire logic [15:0] thread_task_ofs_i,
   input wire logic row_valid_o,
   input wire logic row_ready_i,
   input wire logic [ROW_BITS-1:0] row_data_o,
   input wire logic [2:0] row_index_o,
   input wire logic row_last_o,
   input wire logic [4:0] prim_read_len_o
);
   logic [31:0] ctrl_q;
   logic [21:0] scr_q;
   logic [1:0] simd_q;
   logic [10:0] base_q;
   logic [15:0] ext_q;
   logic [15:0] mofs_q;
   logic [8:0] sel_q;
   logic [15:0] tofs_q;
   wire hdr = row_valid_o && row_index_o == 3'h0;
   wire [31:0] task_dw = ctrl_q[1] ? {7'h0, sel_q, tofs_q} : 32'h0;
   wire [2:0] last_idx = (simd_q == SIMD32 ? 3'h2 : 3'h1) + {2'h0, ctrl_q[0]};
   ////////////////////////////////////////////////////////////////////////
   // shadow of control registers and of the accepted request
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ctrl_q <= RESET_CTRL;
         scr_q <= 22'h0;
      end else if (reg_wr_i && reg_addr_i == ADDR_CTRL) begin
         ctrl_q <= reg_wdata_i & 32'h0000_1f07;
      end else if (reg_wr_i && reg_addr_i == ADDR_SCRATCH) begin
         scr_q <= reg_wdata_i[21:0];
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (thread_valid_i && thread_ready_o) begin
         simd_q <= thread_simd_i;
         base_q <= thread_lane_base_i;
         ext_q <= thread_extent_x_i;
         mofs_q <= thread_mesh_ofs_i;
         sel_q <= thread_task_sel_i;
         tofs_q <= thread_task_ofs_i;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!arst_n_i);
   sequence s_accept;
      thread_valid_i && thread_ready_o;
   endsequence
   sequence s_hdr_out;
      ##2 hdr;
   endsequence
   sequence s_take_last;
      row_valid_o && row_ready_i && row_last_o;
   endsequence
   chk_first_hdr: assert property (s_accept |-> s_hdr_out)
      else $error("header row late after accept");
   chk_row_hold: assert property (row_valid_o && !row_ready_i |=>
      row_valid_o && $stable(row_data_o) && $stable(row_index_o))
      else $error("row changed before taken");
   chk_busy_refuse: assert property (
      row_valid_o |-> !thread_ready_o)
      else $error("request accepted while rows pending");
   chk_last_ends: assert property (s_take_last |=> !row_valid_o)
      else $error("row after last");
   chk_inline_place: assert property (
      s_take_last |-> row_index_o == last_idx)
      else $error("wrong last row number");
   chk_task_ofs: assert property (
      hdr |-> row_data_o[255:224] == task_dw)
      else $error("task offset dword wrong");
   chk_extent_x: assert property (
      hdr && ctrl_q[2] |-> row_data_o[223:208] == ext_q)
      else $error("x extent wrong");
   chk_mesh_ofs: assert property (
      hdr |-> row_data_o[207:192] == mofs_q)
      else $error("mesh offset wrong");
   chk_scratch_idx: assert property (
      hdr |-> row_data_o[191:170] == scr_q)
      else $error("scratch index wrong");
   chk_lane_index: assert property (
      row_valid_o && row_index_o == 3'h1 |->
      row_data_o[31:0] == {{5'h0, base_q} + 16'h1, {5'h0, base_q}})
      else $error("lane index wrong");
   chk_read_len: assert property (prim_read_len_o == ctrl_q[12:8] &&
      prim_read_len_o <= PRIM_READ_LEN_MAX)
      else $error("read length wrong");
endmodule // mesh_payload_monitor

bind mesh_thread_payload_builder mesh_payload_monitor u_mesh_payload_monitor (
   .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
   .thread_valid_i(thread_valid_i), .thread_ready_o(thread_ready_o),
   .thread_simd_i(thread_simd_i), .thread_lane_base_i(thread_lane_base_i),
   .thread_extent_x_i(thread_extent_x_i),
   .thread_mesh_ofs_i(thread_mesh_ofs_i),
   .thread_task_sel_i(thread_task_sel_i),
   .thread_task_ofs_i(thread_task_ofs_i), .row_valid_o(row_valid_o),
   .row_ready_i(row_ready_i), .row_data_o(row_data_o),
   .row_index_o(row_index_o), .row_last_o(row_last_o),
   .prim_read_len_o(prim_read_len_o));

// file: exec_row_sink.sv
// execution unit side: takes payload rows, may stall every other cycle
// assumes rows arrive on the builder row stream, one clock
`timescale 1ns/1ps
module exec_row_sink
   import mesh_payload_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   input wire logic clr_i,
   input wire logic stall_i,
   input wire logic row_valid_i,
   input wire logic [ROW_BITS-1:0] row_data_i,
   input wire logic [2:0] row_index_i,
   input wire logic row_last_i,
   output logic row_ready_o,
   output logic [3:0] n_rows_o,
   output logic [2:0] last_idx_o,
   output logic done_o
);
   logic [ROW_BITS-1:0] rows [0:7];
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         row_ready_o <= 1'b0;
         n_rows_o <= 4'h0;
         last_idx_o <= 3'h0;
         done_o <= 1'b0;
      end else begin
         row_ready_o <= stall_i ? ~row_ready_o : 1'b1;
         if (clr_i) begin
            n_rows_o <= 4'h0;
            done_o <= 1'b0;
         end else if (row_valid_i && row_ready_o) begin
            rows[row_index_i] <= row_data_i;
            n_rows_o <= n_rows_o + 4'h1;
            if (row_last_i) begin
               last_idx_o <= row_index_i;
               done_o <= 1'b1;
            end
         end
      end
   end
endmodule // exec_row_sink

// file: mesh_thread_payload_builder_tb_top.sv
// testbench: register, dispatch and tally tests with a row sink
// assumes the checker is bound from its own file
`timescale 1ns/1ps
module mesh_thread_payload_builder_tb_top;
   import mesh_payload_pkg::*;
   localparam logic [15:0] EXT = 16'h0123;
   localparam logic [15:0] MOFS = 16'h0a40;
   localparam logic [8:0] SEL = 9'h1a5;
   localparam logic [15:0] TOFS = 16'hbeef;
   localparam logic [21:0] SCR = 22'h2a5a5;
   localparam logic [31:0] INL = 32'hc0de_0000;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] addr = 8'h0;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic gstart = 1'b0;
   logic [10:0] gsize = 11'h0;
   logic [1:0] graphics_slice_unit = 2'h0;
   logic tvalid = 1'b0;
   logic [1:0] tsimd = 2'h0;
   logic [10:0] tbase = 11'h0;
   logic tfree = 1'b0;
   logic [9:0] tfree_id = 10'h0;
   logic clr = 1'b0;
   logic stall = 1'b0;
   logic [31:0] rdata;
   logic [255:0] row;
   logic [2:0] ridx, last_idx;
   logic [4:0] plen;
   logic [3:0] n_rows;
   logic tready, rvalid, rready, rlast, done;
   int miscompares = 0;
   int num_checks = 0;
   int cyc = 0;
   always #4 clk = ~clk;
   mesh_thread_payload_builder u_mesh_thread_payload_builder (
      .core_clk_i(clk), .arst_n_i(arst_n), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .group_start_i(gstart), .group_size_i(gsize), .group_slice_i(graphics_slice_unit),
      .thread_valid_i(tvalid), .thread_ready_o(tready), .thread_simd_i(tsimd),
      .thread_lane_base_i(tbase), .thread_extent_x_i(EXT),
      .thread_mesh_ofs_i(MOFS), .thread_task_sel_i(SEL),
      .thread_task_ofs_i(TOFS), .tag_free_i(tfree), .tag_free_id_i(tfree_id),
      .row_valid_o(rvalid), .row_ready_i(rready), .row_data_o(row),
      .row_index_o(ridx), .row_last_o(rlast), .prim_read_len_o(plen));
   exec_row_sink u_exec_row_sink (
      .core_clk_i(clk), .arst_n_i(arst_n), .clr_i(clr), .stall_i(stall),
      .row_valid_i(rvalid), .row_data_i(row), .row_index_i(ridx),
      .row_last_i(rlast), .row_ready_o(rready), .n_rows_o(n_rows),
      .last_idx_o(last_idx), .done_o(done));
   ////////////////////////////////////////////////////////////////////////
   task end_sim();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         miscompares++;
         end_sim();
      end
   end
   task check(input string nm, input logic [255:0] e, input logic [255:0] g);
      num_checks++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 check(nm, {224'h0, e}, {224'h0, rdata});
   endtask
   task tally_chk(input logic [1:0] s, input logic [63:0] e);
      rd_chk("tally_lo", ADDR_TALLY_BASE + {3'h0, s, 3'h0}, e[31:0]);
      rd_chk("tally_hi", ADDR_TALLY_BASE + {3'h0, s, 3'h4}, e[63:32]);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task run_thread(input logic [1:0] s, input logic [10:0] b,
         input logic [2:0] c, input logic [9:0] tag);
      logic [255:0] exp [0:3];
      logic [255:0] got;
      int nr;
      nr = (s == SIMD32 ? 3 : 2) + c[0];
      exp[0] = {c[1] ? {7'h0, SEL, TOFS} : 32'h0, c[2] ? EXT : 16'h0, MOFS,
         SCR, tag, 160'h0};
      exp[1] = 256'h0;
      exp[2] = 256'h0;
      for (int k = 0; k < (8 << s); k++) begin
         exp[1 + k / 16][16 * (k % 16) +: 16] = 16'(b + k);
      end
      for (int i = 0; i < 8; i++) begin
         if (c[0]) exp[nr - 1][32 * i +: 32] = INL + i;
      end
      reg_wr(ADDR_CTRL, {19'h0, b[4:0], 5'h0, c});
      #1;
      check("read_len", 256'(b[4:0]), 256'(plen));
      @(posedge clk);
      clr <= 1'b1;
      tsimd <= s;
      tbase <= b;
      tvalid <= 1'b1;
      for (int k = 0; k < 50 && !tready; k++) @(negedge clk);
      @(posedge clk);
      clr <= 1'b0;
      tvalid <= 1'b0;
      @(negedge clk);
      for (int k = 0; k < 100 && !done; k++) @(negedge clk);
      check("rows", 256'(nr), 256'(n_rows));
      check("last_row", 256'(nr - 1), 256'(last_idx));
      for (int k = 0; k < nr; k++) begin
         got = u_exec_row_sink.rows[k];
         if (k == 0) got[159:0] = 160'h0;
         check("row", exp[k], got);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      rd_chk("ctrl", ADDR_CTRL, RESET_CTRL);
      rd_chk("status", ADDR_STATUS, {27'h0, ST_IDLE});
      rd_chk("unmapped", 8'hfc, 32'h0);
      for (int i = 0; i < 4; i++) tally_chk(2'(i), RESET_TALLY);
      $display("test reset done");
      reg_wr(ADDR_CTRL, 32'hffff_ffff);
      rd_chk("ctrl", ADDR_CTRL, 32'h0000_1f07);
      check("read_len", 256'(PRIM_READ_LEN_MAX), 256'(plen));
      reg_wr(ADDR_STATUS, 32'h0);
      rd_chk("status", ADDR_STATUS, {27'h0, ST_IDLE});
      reg_wr(ADDR_SCRATCH, {10'h0, SCR});
      for (int i = 0; i < 8; i++) begin
         reg_wr(ADDR_INLINE_BASE + 8'(4 * i), INL + i);
      end
      $display("test registers done");
      stall <= 1'b1;
      run_thread(SIMD8, 11'h005, 3'h0, 10'h000);
      run_thread(SIMD16, 11'h010, 3'h7, 10'h001);
      stall <= 1'b0;
      run_thread(SIMD32, 11'h7e0, 3'h5, 10'h002);
      @(posedge clk);
      tfree <= 1'b1;
      @(posedge clk);
      tfree <= 1'b0;
      run_thread(SIMD8, 11'h7f8, 3'h2, 10'h000);
      $display("test dispatch done");
      for (int i = 0; i < 4; i++) tally_chk(2'(i), 64'h0);
      @(posedge clk);
      gstart <= 1'b1;
      graphics_slice_unit <= 2'h1;
      gsize <= 11'h7ff;
      @(posedge clk);
      graphics_slice_unit <= 2'h3;
      gsize <= 11'h005;
      @(posedge clk);
      graphics_slice_unit <= 2'h1;
      gsize <= 11'h7ff;
      @(posedge clk);
      gstart <= 1'b0;
      repeat (2) @(posedge clk);
      tally_chk(2'h1, 64'hffe);
      tally_chk(2'h3, 64'h5);
      tally_chk(2'h0, 64'h0);
      $display("test tally done");
      end_sim();
   end
endmodule // mesh_thread_payload_builder_tb_top
